/* hw/uesq_pkg.sv */
package uesq_pkg;

  // ==========================================================
  // host register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_RXDATA = 8'h18;

  // ==========================================================
  // command bits of the control register (write pulses)
  localparam int CMD_TX_START = 0;
  localparam int CMD_RX_START = 1;
  localparam int CMD_TX_STOP = 2;
  localparam int CMD_RX_STOP = 3;
  localparam int CMD_APPLY_CFG = 4;
  localparam int CMD_RX_READ = 5;

  // interrupt status bits
  localparam int IRQ_TX_LOADED = 0;
  localparam int IRQ_SEQ_DONE = 1;
  localparam int IRQ_RX_REFUSED = 2;
  localparam int IRQ_RX_READ = 3;
  localparam int IRQ_W = 4;

  // status register bits
  localparam int ST_TX_ON = 0;
  localparam int ST_RX_ON = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_TX_PEND = 3;
  localparam int ST_LINE_LOW = 4;

  // ==========================================================
  // device register indexes on the device port
  localparam logic [1:0] DEV_MODE = 2'h0;
  localparam logic [1:0] DEV_TXBUF = 2'h1;
  localparam logic [1:0] DEV_TXSTAT = 2'h2;
  localparam logic [1:0] DEV_RXBUF = 2'h3;

  // operation mode register fields
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PAR_HI = 4;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_CLEN = 2;
  // transmit status register: buffer-full flag
  localparam int TXSTAT_FULL = 1;

  // ==========================================================
  // reset values and timing
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;
  // rising base clock edges to wait: two guarantee one whole base period
  localparam logic [1:0] BASE_EDGES = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_TX_PWR  = 4'h1,
    ST_TX_EN   = 4'h2,
    ST_TX_WAIT = 4'h3,
    ST_RX_PWR  = 4'h4,
    ST_RX_EN   = 4'h5,
    ST_RX_WAIT = 4'h6,
    ST_TX_OFF  = 4'h7,
    ST_RX_OFF  = 4'h8,
    ST_PWR_OFF = 4'h9,
    ST_POLL    = 4'hA,
    ST_LOAD    = 4'hB,
    ST_CFG_OFF = 4'hC,
    ST_CFG_SET = 4'hD,
    ST_RX_RD   = 4'hE
  } uesq_state_e;

endpackage

/* hw/uesq_dev_port.sv */
`timescale 1ns/1ps
`default_nettype none
// one register access on the device port: strobe in cycle 1,
// data sampled in cycle 2, done pulse with data in cycle 3
module uesq_dev_port import uesq_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic go,
  input wire logic go_wr,
  input wire logic [1:0] go_addr,
  input wire logic [7:0] go_data,
  output logic [1:0] dev_addr,
  output logic [7:0] dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [7:0] dev_rdata,
  output logic done,
  output logic [7:0] rdata
);
  logic [1:0] addr_ff, nxt_addr;
  logic [7:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic wr_ff, nxt_wr, rd_ff, nxt_rd, smp_ff, nxt_smp, done_ff, nxt_done;

  // ==========================================================
  // next values
  always_comb begin
    nxt_addr = go ? go_addr : addr_ff;
    nxt_wdata = go ? go_data : wdata_ff;
    nxt_wr = go & go_wr;
    nxt_rd = go & ~go_wr;
    nxt_smp = wr_ff | rd_ff;
    nxt_done = smp_ff;
    // read data stand only in the cycle after the strobe
    nxt_rdata = smp_ff ? dev_rdata : rdata_ff;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      addr_ff <= 2'h0;
      wdata_ff <= 8'h00;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      smp_ff <= 1'b0;
      done_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else if (ce) begin
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      smp_ff <= nxt_smp;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
    end
  end

  assign dev_addr = addr_ff;
  assign dev_wdata = wdata_ff;
  assign dev_wr = wr_ff;
  assign dev_rd = rd_ff;
  assign done = done_ff;
  assign rdata = rdata_ff;
endmodule
`default_nettype wire

/* hw/uesq_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - first transmit byte only after base wait
// - never load buffer while full flag set
// - a same-value byte written again is loaded again
// - check full flag before each repeat byte
// - power first, then transmit enable, then data
// - stop: transmit enable off, then power off
// - power, then receive enable, then base wait
// - stop: receive enable off, then power off
// - receive start only with idle-high line
// - enables cleared before parity, length change
module uesq_top import uesq_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  output logic [1:0] dev_addr,
  output logic [7:0] dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [7:0] dev_rdata,
  input wire logic base_clock,
  input wire logic serial_receive_input
);

  // ==========================================================
  // mode word for the device's operation mode register
  function automatic logic [7:0] mode_word(input logic pwr, input logic txe,
                                          input logic rxe, input logic [2:0] cfg);
    logic [7:0] m;
    m = 8'h00;
    m[MODE_POWER] = pwr;
    m[MODE_TXE] = txe;
    m[MODE_RXE] = rxe;
    m[MODE_PAR_HI] = cfg[2];
    m[MODE_PAR_LO] = cfg[1];
    m[MODE_CLEN] = cfg[0];
    return m;
  endfunction

  uesq_state_e state_ff, nxt_state;
  logic op_busy_ff, nxt_op_busy;
  logic tx_on_ff, nxt_tx_on, rx_on_ff, nxt_rx_on;
  logic [2:0] cfg_ff, nxt_cfg, cfg_act_ff, nxt_cfg_act;
  logic [7:0] txbuf_ff, nxt_txbuf, rxbuf_ff, nxt_rxbuf;
  logic tx_pend_ff, nxt_tx_pend;
  logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat, irq_mask_ff, nxt_irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [7:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  logic [1:0] edge_cnt_ff, nxt_edge_cnt;

  logic go, go_wr, op_done;
  logic [1:0] go_addr;
  logic [7:0] go_data, op_rdata;
  logic ctrl_wr, idle, base_rise, wait_done;

  assign ctrl_wr = wr && (addr == REG_CTRL);
  assign idle = (state_ff == ST_IDLE);
  assign wait_done = (edge_cnt_ff == BASE_EDGES);

  uesq_dev_port u_port (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .go(go),
    .go_wr(go_wr),
    .go_addr(go_addr),
    .go_data(go_data),
    .dev_addr(dev_addr),
    .dev_wdata(dev_wdata),
    .dev_wr(dev_wr),
    .dev_rd(dev_rd),
    .dev_rdata(dev_rdata),
    .done(op_done),
    .rdata(op_rdata)
  );

  // base clock rising edges for the enable-to-use waits
  uesq_edge_det u_base_edge (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .sig(base_clock),
    .rise(base_rise)
  );

  // ==========================================================
  // base clock edge counter used for the enable-to-use waits
  always_comb begin
    nxt_edge_cnt = edge_cnt_ff;
    if (state_ff != ST_TX_WAIT && state_ff != ST_RX_WAIT) begin
      nxt_edge_cnt = 2'h0;
    end else if (base_rise && !wait_done) begin
      nxt_edge_cnt = edge_cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      edge_cnt_ff <= 2'h0;
    end else if (ce) begin
      edge_cnt_ff <= nxt_edge_cnt;
    end
  end

  // ==========================================================
  // sequencer: one device access per operating state
  always_comb begin
    nxt_state = state_ff;
    nxt_op_busy = op_busy_ff;
    nxt_tx_on = tx_on_ff;
    nxt_rx_on = rx_on_ff;
    nxt_cfg_act = cfg_act_ff;
    nxt_rxbuf = rxbuf_ff;
    irq_set = '0;
    go = 1'b0;
    go_wr = 1'b1;
    go_addr = DEV_MODE;
    go_data = 8'h00;
    // issue once on entry, leave on the done pulse
    if (!idle && state_ff != ST_TX_WAIT && state_ff != ST_RX_WAIT) begin
      go = ~op_busy_ff;
      nxt_op_busy = op_done ? 1'b0 : 1'b1;
    end
    case (state_ff)
      ST_IDLE: begin
        // commands are taken only here; a busy sequencer ignores them
        if (ctrl_wr && wdata[CMD_TX_START]) begin
          nxt_state = ST_TX_PWR;
        end else if (ctrl_wr && wdata[CMD_RX_START]) begin
          if (serial_receive_input) begin
            nxt_state = ST_RX_PWR;
          end else begin
            irq_set[IRQ_RX_REFUSED] = 1'b1;
          end
        end else if (ctrl_wr && wdata[CMD_TX_STOP]) begin
          nxt_state = ST_TX_OFF;
        end else if (ctrl_wr && wdata[CMD_RX_STOP]) begin
          nxt_state = ST_RX_OFF;
        end else if (ctrl_wr && wdata[CMD_APPLY_CFG]) begin
          nxt_state = ST_CFG_OFF;
        end else if (ctrl_wr && wdata[CMD_RX_READ]) begin
          nxt_state = ST_RX_RD;
        end else if (tx_pend_ff && tx_on_ff) begin
          // any byte taken while not pending starts a load, same value or not
          nxt_state = ST_POLL;
        end
      end
      ST_TX_PWR: begin
        go_data = mode_word(1'b1, tx_on_ff, rx_on_ff, cfg_act_ff);
        if (op_done) nxt_state = ST_TX_EN;
      end
      ST_TX_EN: begin
        go_data = mode_word(1'b1, 1'b1, rx_on_ff, cfg_act_ff);
        if (op_done) nxt_state = ST_TX_WAIT;
      end
      ST_TX_WAIT: begin
        // data may follow only after a whole base clock period
        if (wait_done) begin
          nxt_tx_on = 1'b1;
          irq_set[IRQ_SEQ_DONE] = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_RX_PWR: begin
        go_data = mode_word(1'b1, tx_on_ff, rx_on_ff, cfg_act_ff);
        if (op_done) nxt_state = ST_RX_EN;
      end
      ST_RX_EN: begin
        go_data = mode_word(1'b1, tx_on_ff, 1'b1, cfg_act_ff);
        if (op_done) nxt_state = ST_RX_WAIT;
      end
      ST_RX_WAIT: begin
        if (wait_done) begin
          nxt_rx_on = 1'b1;
          irq_set[IRQ_SEQ_DONE] = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_TX_OFF: begin
        go_data = mode_word(1'b1, 1'b0, rx_on_ff, cfg_act_ff);
        if (op_done) begin
          nxt_tx_on = 1'b0;
          nxt_state = rx_on_ff ? ST_IDLE : ST_PWR_OFF;
          irq_set[IRQ_SEQ_DONE] = rx_on_ff;
        end
      end
      ST_RX_OFF: begin
        go_data = mode_word(1'b1, tx_on_ff, 1'b0, cfg_act_ff);
        if (op_done) begin
          nxt_rx_on = 1'b0;
          nxt_state = tx_on_ff ? ST_IDLE : ST_PWR_OFF;
          irq_set[IRQ_SEQ_DONE] = tx_on_ff;
        end
      end
      ST_PWR_OFF: begin
        // power drops only once both enables are already low
        go_data = mode_word(1'b0, 1'b0, 1'b0, cfg_act_ff);
        if (op_done) begin
          irq_set[IRQ_SEQ_DONE] = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_POLL: begin
        go_wr = 1'b0;
        go_addr = DEV_TXSTAT;
        if (op_done) begin
          // full flag set: poll again, never overwrite a waiting byte
          nxt_state = op_rdata[TXSTAT_FULL] ? ST_POLL : ST_LOAD;
        end
      end
      ST_LOAD: begin
        go_addr = DEV_TXBUF;
        go_data = txbuf_ff;
        if (op_done) begin
          irq_set[IRQ_TX_LOADED] = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_CFG_OFF: begin
        // the power bit is kept so enables drop before power; ST_CFG_SET then cuts power
        go_data = mode_word(tx_on_ff | rx_on_ff, 1'b0, 1'b0, cfg_act_ff);
        if (op_done) begin
          nxt_tx_on = 1'b0;
          nxt_rx_on = 1'b0;
          nxt_state = ST_CFG_SET;
        end
      end
      ST_CFG_SET: begin
        go_data = mode_word(1'b0, 1'b0, 1'b0, cfg_ff);
        if (op_done) begin
          nxt_cfg_act = cfg_ff;
          irq_set[IRQ_SEQ_DONE] = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_RX_RD: begin
        go_wr = 1'b0;
        go_addr = DEV_RXBUF;
        if (op_done) begin
          nxt_rxbuf = op_rdata;
          irq_set[IRQ_RX_READ] = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_op_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      op_busy_ff <= 1'b0;
      tx_on_ff <= 1'b0;
      rx_on_ff <= 1'b0;
      cfg_act_ff <= CFG_RESET;
      rxbuf_ff <= 8'h00;
    end else if (ce) begin
      state_ff <= nxt_state;
      op_busy_ff <= nxt_op_busy;
      tx_on_ff <= nxt_tx_on;
      rx_on_ff <= nxt_rx_on;
      cfg_act_ff <= nxt_cfg_act;
      rxbuf_ff <= nxt_rxbuf;
    end
  end

  // ==========================================================
  // host registers: config, transmit holding byte, irq, read data
  always_comb begin
    nxt_cfg = (wr && addr == REG_CFG) ? wdata[2:0] : cfg_ff;
    nxt_irq_mask = (wr && addr == REG_IRQ_MASK) ? wdata[IRQ_W-1:0] : irq_mask_ff;
    nxt_txbuf = txbuf_ff;
    nxt_tx_pend = tx_pend_ff;
    if (state_ff == ST_LOAD && op_done) nxt_tx_pend = 1'b0;
    // one byte is held; a second write while pending is dropped
    if (wr && addr == REG_TXDATA && !tx_pend_ff) begin
      nxt_txbuf = wdata;
      nxt_tx_pend = 1'b1;
    end
    // read clears, but a new event in the same cycle survives
    nxt_irq_stat = irq_stat_ff;
    if (rd && addr == REG_IRQ_STAT) nxt_irq_stat = '0;
    nxt_irq_stat = nxt_irq_stat | irq_set;
    nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    nxt_rdata = 8'h00;
    if (rd) begin
      case (addr)
        REG_CFG: nxt_rdata = {5'h00, cfg_ff};
        REG_TXDATA: nxt_rdata = txbuf_ff;
        REG_STATUS: begin
          nxt_rdata[ST_TX_ON] = tx_on_ff;
          nxt_rdata[ST_RX_ON] = rx_on_ff;
          nxt_rdata[ST_BUSY] = ~idle;
          nxt_rdata[ST_TX_PEND] = tx_pend_ff;
          nxt_rdata[ST_LINE_LOW] = ~serial_receive_input;
        end
        REG_IRQ_STAT: nxt_rdata = {4'h0, irq_stat_ff};
        REG_IRQ_MASK: nxt_rdata = {4'h0, irq_mask_ff};
        REG_RXDATA: nxt_rdata = rxbuf_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_ff <= CFG_RESET;
      irq_mask_ff <= MASK_RESET;
      txbuf_ff <= 8'h00;
      tx_pend_ff <= 1'b0;
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else if (ce) begin
      cfg_ff <= nxt_cfg;
      irq_mask_ff <= nxt_irq_mask;
      txbuf_ff <= nxt_txbuf;
      tx_pend_ff <= nxt_tx_pend;
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;
  assign irq = irq_ff;
endmodule
`default_nettype wire

/* hw/uesq_unused_placeholder_none.sv */
`timescale 1ns/1ps
`default_nettype none
// rising-edge detector for the device base clock; the history flop
// starts low, so a base clock already high after reset counts once
module uesq_edge_det (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic sig,
  output logic rise
);
  logic prev_ff, nxt_prev;

  // ==========================================================
  // history of the sampled level
  always_comb begin
    nxt_prev = sig;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_ff <= 1'b0;
    end else if (ce) begin
      prev_ff <= nxt_prev;
    end
  end

  // combinational on purpose: the edge is seen in the cycle it arrives
  assign rise = sig & ~prev_ff;
endmodule
`default_nettype wire

/* test/uesq_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// device-port ordering checks
module uesq_top_asserts import uesq_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic [1:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  input wire logic [7:0] dev_rdata,
  input wire logic base_clock,
  input wire logic serial_receive_input
);
  logic [7:0] mode_ff, nxt_mode;
  logic [1:0] bcnt_ff, nxt_bcnt;
  logic bd_ff, poll_ff, free_ff, nxt_free;
  // shadow mode, base edges since enable, last full-flag poll result
  always_comb begin
    nxt_mode = mode_ff;
    nxt_bcnt = bcnt_ff;
    nxt_free = free_ff;
    if (base_clock && !bd_ff && bcnt_ff != 2'h2) nxt_bcnt = bcnt_ff + 2'h1;
    if (dev_wr && dev_addr == DEV_MODE) begin
      nxt_mode = dev_wdata;
      if (dev_wdata[MODE_TXE] && !mode_ff[MODE_TXE]) nxt_bcnt = 2'h0;
    end
    if (poll_ff) nxt_free = !dev_rdata[TXSTAT_FULL];
    // a load uses up the poll: each repeat byte needs a fresh one
    if (dev_wr && dev_addr == DEV_TXBUF) nxt_free = 1'b0;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode_ff <= 8'h00;
      bcnt_ff <= 2'h0;
      bd_ff <= 1'b0;
      poll_ff <= 1'b0;
      free_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      bcnt_ff <= nxt_bcnt;
      bd_ff <= base_clock;
      poll_ff <= dev_rd && dev_addr == DEV_TXSTAT;
      free_ff <= nxt_free;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_mode_wr;
    dev_wr && dev_addr == DEV_MODE;
  endsequence
  sequence s_buf_wr;
    dev_wr && dev_addr == DEV_TXBUF;
  endsequence
  a_tx_power_first: assert property (s_mode_wr ##0 (dev_wdata[MODE_TXE] && !mode_ff[MODE_TXE]) |-> mode_ff[MODE_POWER]) else $error("transmit enabled before power");
  a_rx_power_first: assert property (s_mode_wr ##0 (dev_wdata[MODE_RXE] && !mode_ff[MODE_RXE]) |-> mode_ff[MODE_POWER]) else $error("receive enabled before power");
  a_rx_line_idle: assert property (s_mode_wr ##0 (dev_wdata[MODE_RXE] && !mode_ff[MODE_RXE]) |-> serial_receive_input) else $error("receive enabled with line low");
  a_tx_off_first: assert property (s_mode_wr ##0 !dev_wdata[MODE_POWER] |-> !mode_ff[MODE_TXE] && !dev_wdata[MODE_TXE]) else $error("power cut with transmit on");
  a_rx_off_first: assert property (s_mode_wr ##0 !dev_wdata[MODE_POWER] |-> !mode_ff[MODE_RXE] && !dev_wdata[MODE_RXE]) else $error("power cut with receive on");
  a_cfg_enables_off: assert property (s_mode_wr ##0 (dev_wdata[4:2] != mode_ff[4:2]) |-> (mode_ff[6:5] == 2'h0) && (dev_wdata[6:5] == 2'h0)) else $error("format changed while enabled");
  a_load_after_wait: assert property (s_buf_wr |-> bcnt_ff == 2'h2 && mode_ff[MODE_TXE] && mode_ff[MODE_POWER]) else $error("load before base wait");
  a_load_when_free: assert property (s_buf_wr |-> free_ff) else $error("load without empty poll");
endmodule
`default_nettype wire

/* test/uesq_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// behavioural serial unit behind the device port
module uesq_dev_model import uesq_pkg::*; #(parameter logic [7:0] RX_BYTE = 8'h3C) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  output logic [7:0] dev_rdata,
  output logic base_clock,
  input wire logic serial_receive_input,
  output logic [7:0] mode_o,
  output logic [7:0] last_tx_o,
  output logic [3:0] loads_o,
  output logic rx_on_o,
  output logic rx_bad_o
);
  logic [1:0] div_ff;
  logic [5:0] shift_ff;
  logic full_ff, arm_ff, bd_ff;
  assign base_clock = div_ff[1];
  // one process: the model trades idiom for brevity
  always_ff @(posedge clk) begin
    div_ff <= div_ff + 2'h1;
    bd_ff <= base_clock;
    // a released bus never keeps showing the last value
    dev_rdata <= ~dev_rdata;
    if (dev_rd) begin
      case (dev_addr)
        DEV_MODE: dev_rdata <= mode_o;
        DEV_TXBUF: dev_rdata <= last_tx_o;
        DEV_TXSTAT: dev_rdata <= {6'h00, full_ff, 1'b0};
        default: dev_rdata <= RX_BYTE;
      endcase
    end
    if (dev_wr && dev_addr == DEV_MODE) begin
      mode_o <= dev_wdata;
      arm_ff <= dev_wdata[MODE_RXE] && !mode_o[MODE_RXE];
    end
    // shifter takes the byte when idle; frame of 20 plus two extra clocks
    if (shift_ff != 6'h00) shift_ff <= shift_ff - 6'h01;
    else if (full_ff && mode_o[MODE_TXE]) begin
      full_ff <= 1'b0;
      shift_ff <= 6'h16;
    end
    if (dev_wr && dev_addr == DEV_TXBUF) begin
      full_ff <= 1'b1;
      last_tx_o <= dev_wdata;
      loads_o <= loads_o + 4'h1;
    end
    // reception opens on the next base clock rise after enable, flagged bad if line low
    if (arm_ff && base_clock && !bd_ff) begin
      arm_ff <= 1'b0;
      rx_on_o <= 1'b1;
      if (!serial_receive_input) rx_bad_o <= 1'b1;
    end
    if (!mode_o[MODE_POWER]) begin
      full_ff <= 1'b0;
      shift_ff <= 6'h00;
      rx_on_o <= 1'b0;
      arm_ff <= 1'b0;
    end
    if (!reset_n) begin
      {div_ff, shift_ff, full_ff, arm_ff, bd_ff, dev_rdata} <= '0;
      {mode_o, last_tx_o, loads_o, rx_on_o, rx_bad_o} <= '0;
    end
  end
endmodule
`default_nettype wire

/* test/tb_uesq_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_uesq_top;
  import uesq_pkg::*;
  logic clk, reset_n, ce, wr, rd, irq, dev_wr, dev_rd, base_clock, sri, rx_on, rx_bad;
  logic [7:0] addr, wdata, rdata, dev_wdata, dev_rdata, mode, last_tx, s;
  logic [1:0] dev_addr;
  logic [3:0] loads;
  int failures, samples_checked;
  uesq_top dut (.clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata), .base_clock(base_clock),
    .serial_receive_input(sri));
  uesq_dev_model dev (.clk(clk), .reset_n(reset_n), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata), .base_clock(base_clock),
    .serial_receive_input(sri), .mode_o(mode), .last_tx_o(last_tx), .loads_o(loads),
    .rx_on_o(rx_on), .rx_bad_o(rx_bad));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========
  // host port tasks, all entered just after a rising edge
  task host_wr(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    // idle cycle: the next call never re-raises wr in this time step
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task host_rd(input logic [7:0] a, output logic [7:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task chk_irq(input logic exp);
    @(negedge clk);
    check({7'h00, irq}, {7'h00, exp});
    @(posedge clk);
  endtask
  task complete_run;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // polls status; a sequence that never settles ends the run
  task wait_st(input logic [7:0] m, input logic [7:0] v);
    logic [7:0] q;
    for (int i = 0; i < 100; i++) begin
      host_rd(REG_STATUS, q);
      if ((q & m) === v) return;
    end
    failures++;
    complete_run();
  endtask
  // ==========
  // main sequence
  initial begin
    {reset_n, wr, rd, addr, wdata, failures, samples_checked} = '0;
    ce = 1'b1;
    sri = 1'b1;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    host_rd(REG_STATUS, s);
    check(s, 8'h00);
    host_rd(REG_IRQ_MASK, s);
    check(s, 8'h00);
    host_rd(8'h1C, s);
    check(s, 8'h00);
    // clock enable low: a register write is frozen out
    ce <= 1'b0;
    host_wr(REG_IRQ_MASK, 8'h0F);
    ce <= 1'b1;
    host_rd(REG_IRQ_MASK, s);
    check(s, 8'h00);
    chk_irq(1'b0);
    host_wr(REG_IRQ_MASK, 8'h0F);
    host_wr(REG_CTRL, 8'h01);
    wait_st(8'h05, 8'h01);
    check(mode, 8'hC0);
    chk_irq(1'b1);
    host_rd(REG_IRQ_STAT, s);
    check(s, 8'h02);
    host_rd(REG_IRQ_STAT, s);
    check(s, 8'h00);
    chk_irq(1'b0);
    // same byte twice, then a write while still pending is refused
    host_wr(REG_TXDATA, 8'h55);
    wait_st(8'h08, 8'h00);
    host_wr(REG_TXDATA, 8'h55);
    host_wr(REG_TXDATA, 8'h66);
    wait_st(8'h0C, 8'h00);
    check(last_tx, 8'h55);
    check({4'h0, loads}, 8'h02);
    host_rd(REG_IRQ_STAT, s);
    check(s, 8'h01);
    // line low: start refused, masked event stays silent
    host_wr(REG_IRQ_MASK, 8'h0B);
    sri <= 1'b0;
    repeat (4) @(posedge clk);
    host_wr(REG_CTRL, 8'h02);
    wait_st(8'h04, 8'h00);
    host_rd(REG_STATUS, s);
    check(s, 8'h11);
    chk_irq(1'b0);
    host_rd(REG_IRQ_STAT, s);
    check(s, 8'h04);
    sri <= 1'b1;
    repeat (4) @(posedge clk);
    host_wr(REG_CTRL, 8'h02);
    wait_st(8'h06, 8'h02);
    check(mode, 8'hE0);
    check({6'h00, rx_bad, rx_on}, 8'h01);
    host_wr(REG_CTRL, 8'h20);
    wait_st(8'h04, 8'h00);
    host_rd(REG_RXDATA, s);
    check(s, 8'h3C);
    host_rd(REG_IRQ_STAT, s);
    check(s & 8'h08, 8'h08);
    host_wr(REG_CTRL, 8'h04);
    wait_st(8'h05, 8'h00);
    check(mode, 8'hA0);
    host_wr(REG_CTRL, 8'h08);
    wait_st(8'h06, 8'h00);
    check(mode, 8'h00);
    // format change from a running unit ends stopped
    host_wr(REG_CTRL, 8'h01);
    wait_st(8'h05, 8'h01);
    host_wr(REG_CFG, 8'h05);
    host_rd(REG_CFG, s);
    check(s, 8'h05);
    host_wr(REG_CTRL, 8'h10);
    wait_st(8'h07, 8'h00);
    check(mode, 8'h14);
    complete_run();
  end
endmodule
bind uesq_top uesq_top_asserts chk (.clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .dev_addr(dev_addr),
  .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata),
  .base_clock(base_clock), .serial_receive_input(serial_receive_input));
`default_nettype wire
